/* rtl/tlr_limit_map.vh */
// Address, pointer, mask and reset constants for the limit register pair
`ifndef TLR_LIMIT_MAP_VH
`define TLR_LIMIT_MAP_VH

// Fixed upper four bits of the seven-bit bus address
`define TLR_ADDR_PREFIX 4'h9

// Pointer values that select the two limit registers
`define TLR_PTR_LOW 8'h02
`define TLR_PTR_HIGH 8'h03

// Field layout of a limit word
`define TLR_SIGN_BIT 15
`define TLR_UPPER_MSB 15
`define TLR_UPPER_LSB 8
`define TLR_LOWER_MSB 7
`define TLR_LOWER_LSB 0

// Unused low bits at 9-bit resolution; shifted right once per extra bit
`define TLR_UNUSED_9BIT 16'h007F

// Reset values of the control state
`define TLR_RST_WORD 16'h0000
`define TLR_RST_BYTE 8'h00
`define TLR_RST_PTR 8'h00
`define TLR_RST_BITCNT 4'h0

// Bit count of one byte on the link
`define TLR_BYTE_BITS 4'h8

`endif

/* rtl/tlr_limit_regs.v */
// Two-wire slave holding the low and high temperature limit registers
`include "tlr_limit_map.vh"

module tlr_limit_regs
(
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Two-wire link pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_o,
    // Address straps
    input wire [2:0] address_select_pins_i,
    // Configuration and status from the rest of the device
    input wire resolution_select_hi_i,
    input wire resolution_select_lo_i,
    input wire nv_busy_flag_i,
    input wire reg_lock_bit_i,
    input wire permanent_lockdown_bit_i,
    // Nonvolatile copies of the limits
    input wire [15:0] nv_low_limit_i,
    input wire [15:0] nv_high_limit_i,
    // Limits and events toward the alarm logic
    output wire [15:0] low_limit_o,
    output wire [15:0] high_limit_o,
    output wire fault_clr_o,
    output wire [7:0] pointer_o
);

    localparam [2:0] ST_IDLE = 3'b000;
    localparam [2:0] ST_ADDR = 3'b001;
    localparam [2:0] ST_PTR = 3'b010;
    localparam [2:0] ST_DATA = 3'b011;
    localparam [2:0] ST_ACK = 3'b100;
    localparam [2:0] ST_TX = 3'b101;
    localparam [2:0] ST_RACK = 3'b110;

    // Pin synchronisers; stage one is read only by stage two
    reg scl_s1_q;
    reg scl_s2_q;
    reg scl_s3_q;
    reg sda_s1_q;
    reg sda_s2_q;
    reg sda_s3_q;

    reg [2:0] st_q;
    reg [2:0] nxt_q;
    reg [3:0] bit_q;
    reg [7:0] rx_sh_q;
    reg [7:0] tx_sh_q;
    reg [7:0] ptr_q;
    reg [7:0] upper_q;
    reg [1:0] byte_cnt_q;
    reg rd_lo_q;
    reg oe_q;
    reg sda_out_q;
    reg load_q;
    reg fault_clr_q;
    reg [15:0] low_q;
    reg [15:0] high_q;

    wire scl_rise;
    wire scl_fall;
    wire start_cond;
    wire stop_cond;
    wire [15:0] rd_word;
    wire [15:0] wr_word;
    wire wr_block;

    // Keep only the bits the current resolution uses
    function [15:0] res_mask;
        input [15:0] val;
        input r_hi;
        input r_lo;
        begin
            res_mask = val & ~(`TLR_UNUSED_9BIT >> {r_hi, r_lo});
        end
    endfunction

    // Word presented for a read at the current pointer
    function [15:0] sel_word;
        input [7:0] ptr;
        input [15:0] lo_val;
        input [15:0] hi_val;
        begin
            if (ptr == `TLR_PTR_LOW)
            begin
                sel_word = lo_val;
            end
            else if (ptr == `TLR_PTR_HIGH)
            begin
                sel_word = hi_val;
            end
            else
            begin
                sel_word = `TLR_RST_WORD;
            end
        end
    endfunction

    assign scl_rise = scl_s2_q & ~scl_s3_q;
    assign scl_fall = ~scl_s2_q & scl_s3_q;
    assign start_cond = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;
    assign stop_cond = scl_s2_q & scl_s3_q & sda_s2_q & ~sda_s3_q;

    // Read path masked on the fly, so a resolution change shows at once
    assign rd_word = res_mask(sel_word(ptr_q, low_q, high_q),
        resolution_select_hi_i, resolution_select_lo_i);
    assign wr_word = res_mask({upper_q, rx_sh_q},
        resolution_select_hi_i, resolution_select_lo_i);
    assign wr_block = reg_lock_bit_i | permanent_lockdown_bit_i;

    assign sda_o = sda_out_q;
    assign sda_oe_o = oe_q;
    assign low_limit_o = low_q;
    assign high_limit_o = high_q;
    assign fault_clr_o = fault_clr_q;
    assign pointer_o = ptr_q;

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_i;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_i;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    always @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            st_q <= ST_IDLE;
            nxt_q <= ST_IDLE;
            bit_q <= `TLR_RST_BITCNT;
            rx_sh_q <= `TLR_RST_BYTE;
            tx_sh_q <= `TLR_RST_BYTE;
            ptr_q <= `TLR_RST_PTR;
            upper_q <= `TLR_RST_BYTE;
            byte_cnt_q <= 2'b00;
            rd_lo_q <= 1'b0;
            oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            load_q <= 1'b1;
            fault_clr_q <= 1'b0;
            low_q <= `TLR_RST_WORD;
            high_q <= `TLR_RST_WORD;
        end
        else
        begin
            fault_clr_q <= 1'b0;
            // Open drain: output level stays low, only the enable moves
            sda_out_q <= 1'b0;
            // Nonvolatile copies caught on the first edge after release
            if (load_q)
            begin
                low_q <= nv_low_limit_i;
                high_q <= nv_high_limit_i;
                fault_clr_q <= 1'b1;
                load_q <= 1'b0;
            end
            if (start_cond)
            begin
                // Any pending upper byte is simply dropped
                st_q <= ST_ADDR;
                bit_q <= `TLR_RST_BITCNT;
                oe_q <= 1'b0;
            end
            else if (stop_cond)
            begin
                st_q <= ST_IDLE;
                oe_q <= 1'b0;
            end
            else
            begin
                case (st_q)
                    ST_ADDR, ST_PTR, ST_DATA:
                    begin
                        if (scl_rise && bit_q != `TLR_BYTE_BITS)
                        begin
                            rx_sh_q <= {rx_sh_q[6:0], sda_s2_q};
                            bit_q <= bit_q + 4'h1;
                        end
                        else if (scl_fall && bit_q == `TLR_BYTE_BITS)
                        begin
                            bit_q <= `TLR_RST_BITCNT;
                            if (st_q == ST_ADDR)
                            begin
                                if (rx_sh_q[7:1] == {`TLR_ADDR_PREFIX, address_select_pins_i})
                                begin
                                    oe_q <= 1'b1;
                                    st_q <= ST_ACK;
                                    rd_lo_q <= 1'b0;
                                    tx_sh_q <= rd_word[`TLR_UPPER_MSB:`TLR_UPPER_LSB];
                                    nxt_q <= rx_sh_q[0] ? ST_TX : ST_PTR;
                                end
                                else
                                begin
                                    st_q <= ST_IDLE;
                                end
                            end
                            else if (st_q == ST_PTR)
                            begin
                                ptr_q <= rx_sh_q;
                                oe_q <= 1'b1;
                                st_q <= ST_ACK;
                                nxt_q <= ST_DATA;
                                byte_cnt_q <= 2'b00;
                            end
                            else if (nv_busy_flag_i)
                            begin
                                // No acknowledge; wait for stop or restart
                                st_q <= ST_IDLE;
                            end
                            else
                            begin
                                oe_q <= 1'b1;
                                st_q <= ST_ACK;
                                nxt_q <= ST_DATA;
                                if (byte_cnt_q == 2'b00)
                                begin
                                    upper_q <= rx_sh_q;
                                    byte_cnt_q <= 2'b01;
                                end
                                else if (byte_cnt_q == 2'b01)
                                begin
                                    byte_cnt_q <= 2'b10;
                                    if (!wr_block && ptr_q == `TLR_PTR_LOW)
                                    begin
                                        low_q <= wr_word;
                                        fault_clr_q <= 1'b1;
                                    end
                                    else if (!wr_block && ptr_q == `TLR_PTR_HIGH)
                                    begin
                                        high_q <= wr_word;
                                        fault_clr_q <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (nxt_q == ST_TX)
                            begin
                                // First data bit must appear on this same fall
                                oe_q <= ~tx_sh_q[7];
                                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                bit_q <= 4'h1;
                            end
                            else
                            begin
                                oe_q <= 1'b0;
                            end
                            st_q <= nxt_q;
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_q == `TLR_BYTE_BITS)
                            begin
                                oe_q <= 1'b0;
                                st_q <= ST_RACK;
                            end
                            else
                            begin
                                oe_q <= ~tx_sh_q[7];
                                tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda_s2_q)
                            begin
                                // Nack: line already released
                                st_q <= ST_IDLE;
                            end
                            else
                            begin
                                bit_q <= `TLR_RST_BITCNT;
                                st_q <= ST_TX;
                                rd_lo_q <= ~rd_lo_q;
                                if (rd_lo_q)
                                begin
                                    tx_sh_q <= rd_word[`TLR_UPPER_MSB:`TLR_UPPER_LSB];
                                end
                                else
                                begin
                                    tx_sh_q <= rd_word[`TLR_LOWER_MSB:`TLR_LOWER_LSB];
                                end
                            end
                        end
                    end
                    default:
                    begin
                        oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // tlr_limit_regs

/* sim/tlr_i2c_master.sv */
// Two-wire bus master model facing the limit registers
module tlr_i2c_master
(
    // Link
    output logic scl_o,
    output logic sda_o,
    input wire sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    // Clock stays still between frames; 125 ns per bit
    task automatic bit_x(input logic b, output logic r);
        sda_o = b;
        #31;
        scl_o = 1'b1;
        #31;
        r = sda_i;
        #31;
        scl_o = 1'b0;
        #32;
    endtask
    task automatic start();
        sda_o = 1'b1;
        #31;
        scl_o = 1'b1;
        #31;
        sda_o = 1'b0;
        #31;
        scl_o = 1'b0;
        #32;
    endtask
    task automatic stop();
        sda_o = 1'b0;
        #31;
        scl_o = 1'b1;
        #31;
        sda_o = 1'b1;
        #63;
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // A low on the ninth bit asks for more data
    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(~more, r);
    endtask
endmodule // tlr_i2c_master

/* sim/tlr_limit_props_properties.sv */
// Port checks for the limit register pair
module tlr_limit_props
(
    // Clock and reset
    input wire core_clk_i,
    input wire sys_rst_i,
    // Link
    input wire scl_i,
    input wire sda_o,
    input wire sda_oe_o,
    // Controls
    input wire resolution_select_hi_i,
    input wire resolution_select_lo_i,
    input wire nv_busy_flag_i,
    input wire reg_lock_bit_i,
    input wire permanent_lockdown_bit_i,
    input wire [15:0] nv_low_limit_i,
    input wire [15:0] nv_high_limit_i,
    // Limits
    input wire [15:0] low_limit_o,
    input wire [15:0] high_limit_o,
    input wire fault_clr_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire [15:0] unused_mask = 16'h007F >> {resolution_select_hi_i, resolution_select_lo_i};
    sequence s_any_change;
        $changed(low_limit_o) || $changed(high_limit_o);
    endsequence
    // Reset load is raw, so only later changes count as writes
    sequence s_written;
        s_any_change ##0 !$past(sys_rst_i, 2);
    endsequence
    a_reset_load: assert property ($fell(sys_rst_i) |=> low_limit_o == $past(nv_low_limit_i)
        && high_limit_o == $past(nv_high_limit_i) && fault_clr_o)
        else $error("limits not loaded after reset");
    a_change_clears: assert property (s_any_change |-> fault_clr_o)
        else $error("limit change without fault clear");
    a_clr_one_cycle: assert property (fault_clr_o |=> !fault_clr_o)
        else $error("fault clear longer than one cycle");
    a_write_masked: assert property (s_written |->
        (($changed(low_limit_o) ? low_limit_o : high_limit_o) & unused_mask) == 16'h0000)
        else $error("unused low bits stored");
    a_locked_no_write: assert property (s_written |->
        !(nv_busy_flag_i || reg_lock_bit_i || permanent_lockdown_bit_i))
        else $error("limit written while blocked");
    a_commit_at_ack: assert property (s_written |-> ##[0:4] sda_oe_o)
        else $error("limit commit away from acknowledge");
    a_drive_low_only: assert property (sda_oe_o |-> sda_o == 1'b0)
        else $error("data line driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
        else $error("data line changed while clock high");
endmodule // tlr_limit_props

bind tlr_limit_regs tlr_limit_props u_props
(
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .resolution_select_hi_i(resolution_select_hi_i),
    .resolution_select_lo_i(resolution_select_lo_i),
    .nv_busy_flag_i(nv_busy_flag_i),
    .reg_lock_bit_i(reg_lock_bit_i),
    .permanent_lockdown_bit_i(permanent_lockdown_bit_i),
    .nv_low_limit_i(nv_low_limit_i),
    .nv_high_limit_i(nv_high_limit_i),
    .low_limit_o(low_limit_o),
    .high_limit_o(high_limit_o),
    .fault_clr_o(fault_clr_o)
);

/* sim/tlr_limit_regs_bench.sv */
// Self-checking bench for the limit register pair
`include "tlr_limit_map.vh"
`define CHK(a, b) checked++; if ((a) !== (b)) begin n_errors++; $display("BAD t=%0t got %h exp %h", $time, a, b); end
module tlr_limit_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] ADDR_W = 8'h9A;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic res_hi = 1'b0;
    logic res_lo = 1'b0;
    logic busy = 1'b0;
    logic lock = 1'b0;
    logic lockdown = 1'b0;
    wire scl;
    wire m_sda;
    wire oe;
    wire sda = oe ? 1'b0 : m_sda;
    wire [15:0] low_lim;
    wire [15:0] high_lim;
    wire [7:0] ptr;
    int n_errors = 0;
    int checked = 0;
    tlr_i2c_master M
    (
        .scl_o(scl),
        .sda_o(m_sda),
        .sda_i(sda)
    );
    tlr_limit_regs DUT
    (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .scl_i(scl),
        .sda_i(sda),
        .sda_o(),
        .sda_oe_o(oe),
        .address_select_pins_i(3'h5),
        .resolution_select_hi_i(res_hi),
        .resolution_select_lo_i(res_lo),
        .nv_busy_flag_i(busy),
        .reg_lock_bit_i(lock),
        .permanent_lockdown_bit_i(lockdown),
        .nv_low_limit_i(16'h1230),
        .nv_high_limit_i(16'h4560),
        .low_limit_o(low_lim),
        .high_limit_o(high_lim),
        .fault_clr_o(),
        .pointer_o(ptr)
    );
    initial
    begin
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Acks in order: address, pointer, upper, lower, extra
    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [15:0] w,
                      input int nb, input logic [4:0] exp);
        logic [4:0] acks;
        acks = 5'h00;
        M.start();
        M.send_byte(a, acks[4]);
        M.send_byte(p, acks[3]);
        if (nb > 0) M.send_byte(w[15:8], acks[2]);
        if (nb > 1) M.send_byte(w[7:0], acks[1]);
        if (nb > 2) M.send_byte(8'hA5, acks[0]);
        M.stop();
        `CHK(acks, exp)
    endtask
    task automatic rd(input logic rep, input logic [15:0] exp);
        logic ack;
        logic [15:0] d;
        M.start();
        M.send_byte(ADDR_W | 8'h01, ack);
        `CHK(ack, 1'b1)
        M.recv_byte(1'b1, d[15:8]);
        M.recv_byte(rep, d[7:0]);
        `CHK(d, exp)
        if (rep)
        begin
            M.recv_byte(1'b1, d[15:8]);
            M.recv_byte(1'b0, d[7:0]);
            `CHK(d, exp)
        end
        M.stop();
    endtask
    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end
    initial
    begin
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        `CHK(low_lim, 16'h1230)
        `CHK(high_lim, 16'h4560)
        for (int r = 0; r < 4; r++)
        begin
            @(negedge core_clk_i);
            {res_hi, res_lo} = r[1:0];
            wr(ADDR_W, `TLR_PTR_LOW, 16'hFFFF, 2, 5'h1E);
            `CHK(low_lim, 16'hFFFF << (7 - r))
            rd(1'b0, 16'hFFFF << (7 - r));
        end
        // Stored at 12 bits, read back at 9 bits
        @(negedge core_clk_i);
        {res_hi, res_lo} = 2'h0;
        rd(1'b0, 16'hFF80);
        @(negedge core_clk_i);
        {res_hi, res_lo} = 2'h3;
        wr(ADDR_W, `TLR_PTR_HIGH, 16'h7FF0, 3, 5'h1F);
        `CHK(high_lim, 16'h7FF0)
        `CHK(ptr, `TLR_PTR_HIGH)
        rd(1'b1, 16'h7FF0);
        wr(ADDR_W, `TLR_PTR_LOW, 16'h0120, 1, 5'h1C);
        `CHK(low_lim, 16'hFFF0)
        for (int k = 0; k < 2; k++)
        begin
            @(negedge core_clk_i);
            lock = (k == 0);
            lockdown = (k == 1);
            wr(ADDR_W, `TLR_PTR_LOW, 16'h0120, 2, 5'h1E);
            `CHK(low_lim, 16'hFFF0)
        end
        @(negedge core_clk_i);
        lockdown = 1'b0;
        busy = 1'b1;
        wr(ADDR_W, `TLR_PTR_LOW, 16'h0120, 2, 5'h18);
        `CHK(low_lim, 16'hFFF0)
        @(negedge core_clk_i);
        busy = 1'b0;
        wr(8'h92, `TLR_PTR_LOW, 16'h0120, 2, 5'h00);
        wr(ADDR_W, `TLR_PTR_LOW, 16'h0120, 2, 5'h1E);
        `CHK(low_lim, 16'h0120)
        // Pointer outside the pair: acked, nothing stored, reads zero
        wr(ADDR_W, 8'h07, 16'h5550, 2, 5'h1E);
        `CHK(low_lim, 16'h0120)
        `CHK(high_lim, 16'h7FF0)
        rd(1'b0, `TLR_RST_WORD);
        // Second reset in mid-run reloads the nonvolatile copies
        @(negedge core_clk_i);
        sys_rst_i = 1'b1;
        repeat (5) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        `CHK(low_lim, 16'h1230)
        `CHK(high_lim, 16'h4560)
        `CHK(ptr, `TLR_RST_PTR)
        wr(ADDR_W, `TLR_PTR_HIGH, 16'h0000, 0, 5'h18);
        rd(1'b0, 16'h4560);
        stop_test();
    end
endmodule // tlr_limit_regs_bench
